// ### src/msf_pkg.sv
// Package for the module status and flag bank: offsets, fields, codes, carriers.
// Assumes a byte-wide management port in front (two-wire slave decodes bytes).
package msf_pkg;
    // Byte offsets in the low page
    localparam logic [7:0] OFS_TYPE_ID   = 8'h00;
    localparam logic [7:0] OFS_SPEC_REV  = 8'h01;
    localparam logic [7:0] OFS_MGMT_CHAR = 8'h02;
    localparam logic [7:0] OFS_GLB_STAT  = 8'h03;
    localparam logic [7:0] OFS_SUM_BANK0 = 8'h04;
    localparam logic [7:0] OFS_SUM_BANK3 = 8'h07;
    localparam logic [7:0] OFS_EVT_FLAGS = 8'h08;
    localparam logic [7:0] OFS_SUP_TEMP  = 8'h09;
    localparam logic [7:0] OFS_AUX12     = 8'h0a;
    localparam logic [7:0] OFS_CUST_AUX3 = 8'h0b;
    localparam logic [7:0] OFS_RSVD_FLAG = 8'h0c;
    localparam logic [7:0] OFS_VEND_FLAG = 8'h0d;
    localparam logic [7:0] OFS_MASK_EVT  = 8'h1f;
    localparam logic [7:0] OFS_MASK_CUST = 8'h22;
    // Field positions
    localparam int POS_MEM_MODEL  = 7;
    localparam int POS_STEPWISE   = 6;
    localparam int POS_SPEED_LO   = 2;
    localparam int POS_STATE_LO   = 1;
    localparam int POS_IRQ_INACT  = 0;
    localparam int POS_CMD2_DONE  = 7;
    localparam int POS_CMD1_DONE  = 6;
    localparam int POS_FW_FAULT   = 1;
    localparam int POS_STATE_CHG  = 0;
    // Byte 8 defined bits
    localparam logic [7:0] EVT_DEFINED_MASK = 8'hc3;
    // Summary bytes use bits 4-0
    localparam logic [7:0] SUM_DEFINED_MASK = 8'h1f;
    // Reset values
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_MASK  = 8'h00;
    // Module state codes
    localparam logic [2:0] ST_LOW_POWER  = 3'h1;
    localparam logic [2:0] ST_POWER_UP   = 3'h2;
    localparam logic [2:0] ST_READY      = 3'h3;
    localparam logic [2:0] ST_POWER_DOWN = 3'h4;
    localparam logic [2:0] ST_FAULT      = 3'h5;
    localparam logic [2:0] ST_OUT_CHECK  = 3'h6;
    // Speed codes
    localparam logic [1:0] SPEED_400K = 2'h0;
    localparam logic [1:0] SPEED_1M   = 2'h1;
    // Number of latched flag bytes (8..11) and of banks
    localparam int NUM_FLAG_BYTES = 4;
    localparam int NUM_BANKS      = 4;

    // Register port request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } msf_req_t;

    // Monitor event carrier, one nibble per monitor: lw, hw, la, ha
    typedef struct packed {
        logic [3:0] supply;
        logic [3:0] temp;
        logic [3:0] aux2;
        logic [3:0] aux1;
        logic [3:0] vendor;
        logic [3:0] aux3;
    } msf_mon_t;
endpackage

// ### src/msf_flag_byte.sv
// One latched clear-on-read flag byte with its mask and interrupt term.
// Assumes events and the read strobe are on the management clock.
`timescale 1ns/1ps
module msf_flag_byte #(
    parameter logic [7:0] DEFINED = 8'hff
) (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    // Events and access
    input  wire logic [7:0] i_set,
    input  wire logic       i_rd_clr,
    input  wire logic [7:0] i_mask,
    // Results
    output logic      [7:0] o_flags,
    output logic            o_irq
);
    logic [7:0] flag_ff;   // Latched flags

    // Set beats the read clear so an event in the read cycle is kept
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            flag_ff <= msf_pkg::RST_FLAGS;
        end else begin
            flag_ff <= ((i_rd_clr ? 8'h00 : flag_ff) | i_set) & DEFINED;
        end
    end

    assign o_flags = flag_ff;
    // Mask bit set means the flag is kept off the interrupt
    assign o_irq = |(flag_ff & ~i_mask);

    flag_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (!i_rd_clr && $past(flag_ff) != 8'h00 && !$past(i_rd_clr)) |->
        ((flag_ff & $past(flag_ff)) == $past(flag_ff)))
        else $error("latched flag lost without a read");
endmodule // msf_flag_byte

// ### src/msf_status_bank.sv
// Low-page status and flag bank: identity, characteristics, state, summaries, flags.
// Assumes a two-wire slave delivers one-cycle read/write strobes on i_clk_sys.
`timescale 1ns/1ps
module msf_status_bank #(
    parameter logic [7:0] TYPE_ID     = 8'h5a, // Arbitrary identifier value
    parameter logic [3:0] REV_MAJOR   = 4'h1,
    parameter logic [3:0] REV_MINOR   = 4'h0,
    parameter bit         FLAT_MEMORY = 1'b0,
    parameter bit         STEPWISE    = 1'b0,
    parameter logic [1:0] MAX_SPEED   = msf_pkg::SPEED_400K
) (
    // Clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rstn,
    // Management byte port
    input  wire msf_pkg::msf_req_t     i_req,
    output logic                [7:0]  o_rdata,
    // Module state machine and monitors
    input  wire logic           [2:0]  i_module_state,
    input  wire logic                  i_cmd_block1_done,
    input  wire logic                  i_cmd_block2_done,
    input  wire logic                  i_firmware_fault,
    input  wire msf_pkg::msf_mon_t     i_mon_events,
    input  wire logic           [7:0]  i_vendor_flag_set,
    // Per-bank page flag presence: bank x 5 pages
    input  wire logic           [19:0] i_page_flag_any,
    // Datapath apply writes from the control section
    input  wire logic                  i_init_apply_wr,
    input  wire logic                  i_immediate_apply_wr,
    output logic                       o_init_apply_ok,
    output logic                       o_immediate_apply_ok,
    output logic                       o_dp_state_change_ok,
    // Interrupt, active low like the module pin
    output logic                       o_irq_n
);
    localparam int NB = msf_pkg::NUM_FLAG_BYTES + 1; // Bytes 8-11 plus vendor 13

    logic [2:0]  state_prev_ff;      // Last seen state, for change detect
    logic [7:0]  mask_ff [NB];       // Mask bytes 31-34 and 36
    logic [7:0]  flags   [NB];       // Latched flag contents
    logic [7:0]  set_vec [NB];       // Per-byte set events
    logic [NB-1:0] irq_vec;          // Per-byte unmasked activity
    logic [NB-1:0] rd_clr;           // Per-byte read clear
    logic [2:0]  reported_state;     // State field value
    logic [7:0]  nxt_rdata;          // Read mux result
    logic        irq_any;            // Combined interrupt
    logic [4:0]  summary [msf_pkg::NUM_BANKS];

    // Flag byte index for an address, NB when not a flag byte
    function automatic int flag_index(input logic [7:0] a);
        if (a >= msf_pkg::OFS_EVT_FLAGS && a <= msf_pkg::OFS_CUST_AUX3)
            return int'(a - msf_pkg::OFS_EVT_FLAGS);
        else if (a == msf_pkg::OFS_VEND_FLAG)
            return NB - 1;
        return NB;
    endfunction

    // Mask byte index for an address, NB when not a mask byte
    function automatic int mask_index(input logic [7:0] a);
        if (a >= msf_pkg::OFS_MASK_EVT && a <= msf_pkg::OFS_MASK_CUST)
            return int'(a - msf_pkg::OFS_MASK_EVT);
        else if (a == msf_pkg::OFS_MASK_CUST + 8'h02)
            return NB - 1;
        return NB;
    endfunction

    // State changes feed the change flag; reset value avoids a spurious flag
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state_prev_ff <= msf_pkg::ST_LOW_POWER;
        end else begin
            state_prev_ff <= i_module_state;
        end
    end

    // Event vectors per flag byte
    always_comb begin
        set_vec[0] = 8'h00;
        set_vec[0][msf_pkg::POS_CMD2_DONE] = i_cmd_block2_done;
        set_vec[0][msf_pkg::POS_CMD1_DONE] = i_cmd_block1_done;
        set_vec[0][msf_pkg::POS_FW_FAULT]  = i_firmware_fault;
        set_vec[0][msf_pkg::POS_STATE_CHG] = (i_module_state != state_prev_ff);
        set_vec[1] = {i_mon_events.supply, i_mon_events.temp};
        set_vec[2] = {i_mon_events.aux2, i_mon_events.aux1};
        set_vec[3] = {i_mon_events.vendor, i_mon_events.aux3};
        set_vec[4] = i_vendor_flag_set;
    end

    // Flag bytes, cleared by a host read of the byte
    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_flag
            assign rd_clr[g] = i_req.rd && (flag_index(i_req.addr) == g);
            msf_flag_byte #(
                .DEFINED (g == 0 ? msf_pkg::EVT_DEFINED_MASK : 8'hff)
            ) u_byte (
                .i_clk_sys (i_clk_sys),
                .i_rstn    (i_rstn),
                .i_set     (set_vec[g]),
                .i_rd_clr  (rd_clr[g]),
                .i_mask    (mask_ff[g]),
                .o_flags   (flags[g]),
                .o_irq     (irq_vec[g])
            );

            // Host-written mask byte
            always_ff @(posedge i_clk_sys or negedge i_rstn) begin
                if (!i_rstn) begin
                    mask_ff[g] <= msf_pkg::RST_MASK;
                end else if (i_req.wr && mask_index(i_req.addr) == g) begin
                    mask_ff[g] <= i_req.wdata;
                end
            end
        end
    endgenerate

    // Bank summaries track the page flags live, so they drop only
    // after the host has read those flags away at their source
    generate
        for (g = 0; g < msf_pkg::NUM_BANKS; g++) begin : g_sum
            assign summary[g] = i_page_flag_any[g*5 +: 5];
        end
    endgenerate

    assign irq_any = |irq_vec;

    // Flat memory hides internal activity behind the ready code
    always_comb begin
        if (FLAT_MEMORY) begin
            reported_state = msf_pkg::ST_READY;
        end else begin
            reported_state = i_module_state;
        end
    end

    // Read multiplexer; reserved and unmapped bytes read zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (i_req.addr == msf_pkg::OFS_TYPE_ID) begin
            nxt_rdata = TYPE_ID;
        end else if (i_req.addr == msf_pkg::OFS_SPEC_REV) begin
            nxt_rdata = {REV_MAJOR, REV_MINOR};
        end else if (i_req.addr == msf_pkg::OFS_MGMT_CHAR) begin
            nxt_rdata[msf_pkg::POS_MEM_MODEL] = FLAT_MEMORY;
            nxt_rdata[msf_pkg::POS_STEPWISE]  = STEPWISE;
            nxt_rdata[msf_pkg::POS_SPEED_LO +: 2] = MAX_SPEED;
        end else if (i_req.addr == msf_pkg::OFS_GLB_STAT) begin
            nxt_rdata[msf_pkg::POS_STATE_LO +: 3] = reported_state;
            nxt_rdata[msf_pkg::POS_IRQ_INACT] = ~irq_any;
        end else if (i_req.addr >= msf_pkg::OFS_SUM_BANK0 &&
                     i_req.addr <= msf_pkg::OFS_SUM_BANK3) begin
            nxt_rdata = {3'h0, summary[i_req.addr[1:0]]} & msf_pkg::SUM_DEFINED_MASK;
        end else if (i_req.addr == msf_pkg::OFS_RSVD_FLAG) begin
            nxt_rdata = 8'h00;
        end else if (flag_index(i_req.addr) < NB) begin
            nxt_rdata = flags[flag_index(i_req.addr)];
        end else if (mask_index(i_req.addr) < NB) begin
            nxt_rdata = mask_ff[mask_index(i_req.addr)];
        end
    end

    // Registered read data, captured on the read strobe
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_req.rd) begin
            o_rdata <= nxt_rdata;
        end
    end

    // Interrupt pin register, high when idle
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq_n <= 1'b1;
        end else begin
            o_irq_n <= ~irq_any;
        end
    end

    // Apply gating: stepwise mode accepts init writes without state moves
    always_comb begin
        o_init_apply_ok      = i_init_apply_wr;
        o_immediate_apply_ok = i_immediate_apply_wr && !STEPWISE;
        o_dp_state_change_ok = i_init_apply_wr && !STEPWISE;
    end

    irq_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        irq_any |=> !o_irq_n)
        else $error("interrupt not raised for unmasked flag");
    irq_release_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !irq_any |=> o_irq_n)
        else $error("interrupt held with no unmasked flag");
    state_chg_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_module_state != $past(i_module_state)) |=> flags[0][0])
        else $error("state change not latched");
    fw_fault_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_firmware_fault |=> flags[0][1])
        else $error("firmware fault not latched");
    cmd_done_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_cmd_block2_done |=> flags[0][7])
        else $error("command block 2 completion not latched");
    evt_rsvd_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        flags[0][5:2] == 4'h0)
        else $error("reserved event bits set");
    rd_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_req.rd && i_req.addr == msf_pkg::OFS_SUP_TEMP && i_mon_events.supply == 4'h0
         && i_mon_events.temp == 4'h0) |=> flags[1] == 8'h00)
        else $error("supply byte not cleared by read");
    stat_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_req.rd && i_req.addr == msf_pkg::OFS_GLB_STAT) |=>
        (o_rdata[0] == $past(~irq_any) && o_rdata[3:1] == $past(reported_state)))
        else $error("global status read wrong");
    flat_ready_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        FLAT_MEMORY |-> reported_state == msf_pkg::ST_READY)
        else $error("flat memory reports other than ready");
    immed_ign_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        STEPWISE |-> !o_immediate_apply_ok && !o_dp_state_change_ok)
        else $error("stepwise mode let apply through");

    // Read-back of the fixed revision byte; it never moves after reset
    rev_byte_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_req.rd && i_req.addr == msf_pkg::OFS_SPEC_REV) |=>
        (o_rdata == {REV_MAJOR, REV_MINOR}))
        else $error("revision byte read wrong");

    // Memory model bit sits alone at the top of byte 2
    mem_model_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_req.rd && i_req.addr == msf_pkg::OFS_MGMT_CHAR) |=>
        (o_rdata[7] == FLAT_MEMORY && o_rdata[5:4] == 2'h0))
        else $error("memory model bit read wrong");

    // Speed field plus the reserved low pair of byte 2
    speed_field_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_req.rd && i_req.addr == msf_pkg::OFS_MGMT_CHAR) |=>
        (o_rdata[3:2] == MAX_SPEED && o_rdata[1:0] == 2'h0))
        else $error("speed field read wrong");

    // Reserved top bits of every summary byte read zero
    sum_rsvd_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_req.rd && i_req.addr >= msf_pkg::OFS_SUM_BANK0 &&
         i_req.addr <= msf_pkg::OFS_SUM_BANK3) |=> (o_rdata[7:5] == 3'h0))
        else $error("summary reserved bits set");

    // Summary is a live copy, so it drops as soon as the source drops
    sum_live_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_req.rd && i_req.addr == msf_pkg::OFS_SUM_BANK0) |=>
        (o_rdata[4:0] == $past(i_page_flag_any[4:0])))
        else $error("bank 0 summary not live");

    // Reserved flag byte never shows anything
    rsvd_byte_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_req.rd && i_req.addr == msf_pkg::OFS_RSVD_FLAG) |=> (o_rdata == 8'h00))
        else $error("reserved flag byte not zero");

    // First command block completion lands on bit 6
    cmd1_done_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_cmd_block1_done |=> flags[0][6])
        else $error("command block 1 completion not latched");

    // Supply and temperature lanes keep their order in byte 9
    supply_latch_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        1'b1 |=> ((flags[1] & $past({i_mon_events.supply, i_mon_events.temp})) ==
        $past({i_mon_events.supply, i_mon_events.temp})))
        else $error("supply or temperature event not latched");

    // Auxiliary 2 high nibble, auxiliary 1 low nibble
    aux12_latch_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        1'b1 |=> ((flags[2] & $past({i_mon_events.aux2, i_mon_events.aux1})) ==
        $past({i_mon_events.aux2, i_mon_events.aux1})))
        else $error("auxiliary 1 or 2 event not latched");

    // Vendor monitor high nibble, auxiliary 3 low nibble
    aux3_latch_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        1'b1 |=> ((flags[3] & $past({i_mon_events.vendor, i_mon_events.aux3})) ==
        $past({i_mon_events.vendor, i_mon_events.aux3})))
        else $error("vendor or auxiliary 3 event not latched");

    // Host mask write reaches the event mask byte
    mask_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_req.wr && i_req.addr == msf_pkg::OFS_MASK_EVT) |=>
        (mask_ff[0] == $past(i_req.wdata)))
        else $error("event mask write lost");

    // A fully masked byte may never feed the interrupt
    masked_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (mask_ff[1] == 8'hff) |-> !irq_vec[1])
        else $error("masked supply flags raised interrupt");

    // Event in the read cycle survives the clear
    relatch_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (rd_clr[1] && set_vec[1] != 8'h00) |=> (flags[1] != 8'h00))
        else $error("event lost in read cycle");
endmodule // msf_status_bank

// ### verif/msf_host_model.sv
// Host management controller model: byte reads and byte writes on the port.
// Assumes one-cycle request pulses and read data valid one cycle after.
`timescale 1ns/1ps
module msf_host_model (
    // Clock
    input  wire logic              i_clk_sys,
    // Register port
    output msf_pkg::msf_req_t      o_req,
    input  wire logic        [7:0] i_rdata
);
    // Port idle from time zero
    initial o_req = '0;

    // Read one byte; the read is also what clears latched flags
    task automatic rd_byte(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_clk_sys);
        o_req <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
        @(posedge i_clk_sys);
        o_req.rd <= 1'b0;
        // Data settles after the taking edge
        #1 data = i_rdata;
    endtask

    // Write one byte, used for the mask bytes
    task automatic wr_byte(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk_sys);
        o_req <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(posedge i_clk_sys);
        o_req.wr <= 1'b0;
    endtask
endmodule // msf_host_model

// ### verif/testbench.sv
// Self-checking bench for the status and flag bank, host model on the port.
// Assumes default design parameters: paged memory, 400 kHz, not stepwise.
`timescale 1ns/1ps
module testbench;
    logic              clk_sys = 1'b0; // 100 MHz
    logic              rst_n;          // Active low
    msf_pkg::msf_req_t req;            // From host model
    logic        [7:0] rdata;          // Read data
    logic        [2:0] mod_state;      // Module state code
    logic              cmd1, cmd2, fw; // Event pulses
    logic              init_wr, imm_wr;
    logic              init_ok, imm_ok, dp_ok;
    logic              irq_n;
    logic        [7:0] vend_set;       // Vendor byte events
    logic       [19:0] page_any;       // Summary sources
    msf_pkg::msf_mon_t mon;            // Monitor events
    msf_pkg::msf_mon_t m;              // Random monitor pattern
    int                failures = 0;
    int                tests_run = 0;

    // Clock
    always #5 clk_sys = ~clk_sys;

    msf_status_bank dut (
        .i_clk_sys(clk_sys), .i_rstn(rst_n), .i_req(req), .o_rdata(rdata),
        .i_module_state(mod_state), .i_cmd_block1_done(cmd1),
        .i_cmd_block2_done(cmd2), .i_firmware_fault(fw), .i_mon_events(mon),
        .i_vendor_flag_set(vend_set), .i_page_flag_any(page_any),
        .i_init_apply_wr(init_wr), .i_immediate_apply_wr(imm_wr),
        .o_init_apply_ok(init_ok), .o_immediate_apply_ok(imm_ok),
        .o_dp_state_change_ok(dp_ok), .o_irq_n(irq_n)
    );

    msf_host_model host (.i_clk_sys(clk_sys), .o_req(req), .i_rdata(rdata));

    // Compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Read a byte through the host and compare
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] v;
        host.rd_byte(addr, v);
        check($sformatf("byte %h", addr), v, exp);
    endtask

    // One-cycle event pulse on the module-level sources
    task automatic pulse(input logic [2:0] ev, input msf_pkg::msf_mon_t mv);
        @(posedge clk_sys);
        {fw, cmd2, cmd1} <= ev;
        mon <= mv;
        @(posedge clk_sys);
        {fw, cmd2, cmd1} <= 3'h0;
        mon <= '0;
    endtask

    // Expected global status byte
    function automatic logic [7:0] status_exp(input logic [2:0] code, input logic irq_off);
        return {4'h0, code, irq_off};
    endfunction

    // Verdict and end of run
    task automatic end_of_test();
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        mod_state = msf_pkg::ST_LOW_POWER;
        {cmd1, cmd2, fw, init_wr, imm_wr} = 5'h0;
        vend_set = 8'h00;
        page_any = 20'h0;
        mon = '0;
        void'($urandom(52));
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Identity, characteristics, defaults
        rd_chk(msf_pkg::OFS_TYPE_ID, 8'h5a);
        rd_chk(msf_pkg::OFS_SPEC_REV, 8'h10);
        rd_chk(msf_pkg::OFS_MGMT_CHAR, 8'h00);
        rd_chk(msf_pkg::OFS_GLB_STAT, status_exp(msf_pkg::ST_LOW_POWER, 1'b1));
        for (int a = 8; a <= 12; a++) rd_chk(8'(a), 8'h00);
        rd_chk(8'h40, 8'h00);
        // Unmasked fault raises the interrupt two cycles after the event
        pulse(3'h4, '0);
        @(posedge clk_sys);
        #1 check("irq_n", {7'h0, irq_n}, 8'h00);
        rd_chk(msf_pkg::OFS_GLB_STAT, status_exp(msf_pkg::ST_LOW_POWER, 1'b0));
        rd_chk(msf_pkg::OFS_EVT_FLAGS, 8'h02);
        repeat (2) @(posedge clk_sys);
        #1 check("irq_n", {7'h0, irq_n}, 8'h01);
        // Masked fault latches but stays quiet
        host.wr_byte(msf_pkg::OFS_MASK_EVT, 8'h02);
        pulse(3'h4, '0);
        repeat (3) @(posedge clk_sys);
        #1 check("irq_n", {7'h0, irq_n}, 8'h01);
        rd_chk(msf_pkg::OFS_EVT_FLAGS, 8'h02);
        for (int a = 31; a <= 34; a++) host.wr_byte(8'(a), 8'hff);
        // Every state code after low power, each change latching the state flag
        for (int s = 2; s <= 6; s++) begin
            @(posedge clk_sys);
            mod_state <= 3'(s);
            rd_chk(msf_pkg::OFS_GLB_STAT, status_exp(3'(s), 1'b1));
            rd_chk(msf_pkg::OFS_EVT_FLAGS, 8'h01);
        end
        // Command completions and firmware fault together
        pulse(3'h7, '0);
        rd_chk(msf_pkg::OFS_EVT_FLAGS, 8'hc2);
        rd_chk(msf_pkg::OFS_EVT_FLAGS, 8'h00);
        // Random monitor flags, lane order checked per byte
        repeat (20) begin
            m = 24'($urandom);
            pulse(3'h0, m);
            rd_chk(msf_pkg::OFS_SUP_TEMP, {m.supply, m.temp});
            rd_chk(msf_pkg::OFS_AUX12, {m.aux2, m.aux1});
            rd_chk(msf_pkg::OFS_CUST_AUX3, {m.vendor, m.aux3});
        end
        for (int a = 9; a <= 11; a++) rd_chk(8'(a), 8'h00);
        // Held condition re-latches after each read
        @(posedge clk_sys);
        mon <= 24'hffffff;
        rd_chk(msf_pkg::OFS_SUP_TEMP, 8'hff);
        rd_chk(msf_pkg::OFS_SUP_TEMP, 8'hff);
        @(posedge clk_sys);
        mon <= '0;
        rd_chk(msf_pkg::OFS_SUP_TEMP, 8'hff);
        rd_chk(msf_pkg::OFS_SUP_TEMP, 8'h00);
        // Summary bytes: all set, all clear, then random
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            page_any <= (i == 0) ? 20'hfffff : (i == 1) ? 20'h0 : 20'($urandom);
            @(posedge clk_sys);
            for (int b = 0; b < 4; b++)
                rd_chk(8'(4 + b), {3'h0, page_any[b*5 +: 5]});
        end
        // Vendor flag byte
        @(posedge clk_sys);
        vend_set <= 8'ha5;
        @(posedge clk_sys);
        vend_set <= 8'h00;
        rd_chk(msf_pkg::OFS_VEND_FLAG, 8'ha5);
        // Apply writes pass when not stepwise
        @(posedge clk_sys);
        {init_wr, imm_wr} <= 2'h3;
        @(posedge clk_sys);
        #1 check("apply", {5'h0, init_ok, imm_ok, dp_ok}, 8'h07);
        @(posedge clk_sys);
        {init_wr, imm_wr} <= 2'h0;
        end_of_test();
    end

    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
endmodule // testbench
